// *** swc_pkg.sv ***
// Package with constants, modes and carrier types for the sleep and wake-up controller.
package swc_pkg;

  typedef enum logic [2:0] {
    SWC_MODE_IDLE     = 3'h0,
    SWC_MODE_ADC_NR   = 3'h1,
    SWC_MODE_PWR_DOWN = 3'h2,
    SWC_MODE_PWR_SAVE = 3'h3,
    SWC_MODE_RSVD4    = 3'h4,
    SWC_MODE_RSVD5    = 3'h5,
    SWC_MODE_STANDBY  = 3'h6,
    SWC_MODE_EXT_STBY = 3'h7
  } swc_mode_t;

  localparam logic [1:0] SWC_SENSE_LOW     = 2'h0;
  localparam logic [1:0] SWC_SENSE_ANY     = 2'h1;
  localparam logic [1:0] SWC_SENSE_FALL    = 2'h2;
  localparam logic [1:0] SWC_SENSE_RISE    = 2'h3;

  localparam int unsigned SWC_CLK_MHZ      = 200;
  localparam int unsigned SWC_HALT_CYCLES  = 4;
  localparam int unsigned SWC_STBY_CYCLES  = 6;
  localparam int unsigned SWC_TIMEOUT_DEF  = 4096;
  localparam int unsigned SWC_WDT_DIV_DEF  = 200;
  localparam int unsigned SWC_CNT_W        = 20;

  typedef struct packed {
    logic       sleep_arm;
    logic [2:0] sleep_sel;
    logic [1:0] irq_a_sense;
    logic       irq_a_mask;
    logic       global_ie;
    logic       ext_crystal;
    logic       timer2_async_select;
    logic       timer2_irq_en;
    logic       adc_enabled;
  } swc_cfg_t;

  typedef struct packed {
    logic adc_done;
    logic twi_match;
    logic irq_b_level;
    logic irq_c_edge;
    logic timer2_event;
    logic other_irq;
  } swc_wake_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic io_clk_en;
    logic osc_en;
    logic adc_clk_en;
    logic timer2_run;
    logic adc_start;
  } swc_clk_t;

endpackage

// *** swc_irq_sense.sv ***
// Pin synchroniser and sense logic for external interrupt pin a.
`timescale 1ns/1ps
module swc_irq_sense
  import swc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       ext_irq_pin_a,
  input  wire logic [1:0] sense,
  input  wire logic       irq_a_mask,
  input  wire logic       global_ie,
  output logic            irq_req,
  output logic            pin_low
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic hit;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= ext_irq_pin_a;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  always_comb begin
    unique case (sense)
      SWC_SENSE_LOW:  hit = !sync2_reg;
      SWC_SENSE_ANY:  hit = sync2_reg ^ prev_reg;
      SWC_SENSE_FALL: hit = prev_reg & !sync2_reg;
      SWC_SENSE_RISE: hit = !prev_reg & sync2_reg;
    endcase
  end

  assign irq_req = hit & irq_a_mask & global_ie;
  assign pin_low = !sync2_reg;

endmodule

// *** swc_wdt_filter.sv ***
// Two-tick level filter on the watchdog oscillator tick for power-down wake-up.
`timescale 1ns/1ps
module swc_wdt_filter
  import swc_pkg::*;
#(
  parameter int unsigned WDT_DIV = SWC_WDT_DIV_DEF
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic level_in,
  output logic      level_ok
);

  logic [SWC_CNT_W-1:0] div_reg;
  logic [1:0]           samp_reg;
  logic                 tick;

  assign tick = (div_reg == SWC_CNT_W'(WDT_DIV - 1));

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      div_reg <= '0;
    end else if (tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + SWC_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      samp_reg <= 2'h0;
    end else if (!level_in) begin
      samp_reg <= 2'h0;
    end else if (tick) begin
      samp_reg <= {samp_reg[0], 1'b1};
    end
  end

  assign level_ok = samp_reg[1] & level_in;

endmodule

// *** sleep_wakeup_control.sv ***
// Sleep mode sequencer with wake-up sources and resume timing.
`timescale 1ns/1ps
module sleep_wakeup_control
  import swc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = SWC_TIMEOUT_DEF,
  parameter int unsigned WDT_DIV        = SWC_WDT_DIV_DEF
) (
  input  wire logic      sys_clk,
  input  wire logic      reset_n,
  input  wire logic      sleep_instr,
  input  wire logic      instr_done,
  input  wire logic      ext_irq_pin_a,
  input  wire swc_cfg_t  cfg,
  input  wire swc_wake_t wake_src,
  output swc_clk_t       clk_ctrl,
  output logic           sleeping,
  output logic [2:0]     active_mode,
  output logic           irq_a_pending,
  output logic           irq_take,
  output logic           resume_core,
  output logic           timer2_irq_ok
);

  typedef enum logic [2:0] {
    SWC_RUN,
    SWC_SLEEP,
    SWC_TIMEOUT,
    SWC_HALT
  } swc_state_t;

  swc_state_t           state_reg;
  swc_state_t           state_next;
  swc_mode_t            mode_reg;
  logic [SWC_CNT_W-1:0] cnt_reg;
  logic [SWC_CNT_W-1:0] cnt_next;
  logic                 irq_wake_reg;
  logic                 irq_a_req;
  logic                 irq_a_low;
  logic                 level_ok;
  logic                 enter;
  logic                 osc_stopped;
  logic                 wake_irq;
  logic                 wake_any;
  logic                 mode_legal;

  swc_irq_sense u_sense (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .ext_irq_pin_a (ext_irq_pin_a),
    .sense         (cfg.irq_a_sense),
    .irq_a_mask    (cfg.irq_a_mask),
    .global_ie     (cfg.global_ie),
    .irq_req       (irq_a_req),
    .pin_low       (irq_a_low)
  );

  swc_wdt_filter #(
    .WDT_DIV (WDT_DIV)
  ) u_filter (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .level_in (irq_a_low & cfg.irq_a_mask & cfg.global_ie &
               (cfg.irq_a_sense == SWC_SENSE_LOW)),
    .level_ok (level_ok)
  );

  // Reserved codes and standby codes without a crystal do not sleep.
  always_comb begin
    unique case (swc_mode_t'(cfg.sleep_sel))
      SWC_MODE_RSVD4, SWC_MODE_RSVD5: mode_legal = 1'b0;
      SWC_MODE_STANDBY, SWC_MODE_EXT_STBY: mode_legal = cfg.ext_crystal;
      default: mode_legal = 1'b1;
    endcase
  end

  assign enter = sleep_instr & cfg.sleep_arm & mode_legal;

  assign osc_stopped = (mode_reg == SWC_MODE_PWR_DOWN) | (mode_reg == SWC_MODE_PWR_SAVE);

  // Wake sources per mode; a level on pin a is filtered when the oscillator is off.
  always_comb begin
    wake_irq = 1'b0;
    unique case (mode_reg)
      SWC_MODE_IDLE: begin
        wake_irq = irq_a_req | wake_src.adc_done | wake_src.twi_match |
                   wake_src.irq_b_level | wake_src.irq_c_edge |
                   wake_src.timer2_event | wake_src.other_irq;
      end
      SWC_MODE_ADC_NR: begin
        wake_irq = (irq_a_req & (cfg.irq_a_sense == SWC_SENSE_LOW)) |
                   wake_src.adc_done | wake_src.twi_match |
                   wake_src.irq_b_level | wake_src.irq_c_edge |
                   wake_src.timer2_event;
      end
      SWC_MODE_PWR_DOWN, SWC_MODE_STANDBY: begin
        wake_irq = (osc_stopped ? level_ok :
                    (irq_a_req & (cfg.irq_a_sense == SWC_SENSE_LOW))) |
                   wake_src.twi_match | wake_src.irq_b_level | wake_src.irq_c_edge;
      end
      default: begin
        wake_irq = (osc_stopped ? level_ok :
                    (irq_a_req & (cfg.irq_a_sense == SWC_SENSE_LOW))) |
                   wake_src.twi_match | wake_src.irq_b_level | wake_src.irq_c_edge |
                   (wake_src.timer2_event & cfg.timer2_async_select &
                    cfg.timer2_irq_en & cfg.global_ie);
      end
    endcase
  end

  assign wake_any = wake_irq;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      SWC_RUN: begin
        if (enter) begin
          state_next = SWC_SLEEP;
        end
      end
      SWC_SLEEP: begin
        if (wake_any) begin
          if (osc_stopped) begin
            state_next = SWC_TIMEOUT;
            cnt_next   = SWC_CNT_W'(TIMEOUT_CYCLES - 1);
          end else if (mode_reg == SWC_MODE_STANDBY || mode_reg == SWC_MODE_EXT_STBY) begin
            state_next = SWC_TIMEOUT;
            cnt_next   = SWC_CNT_W'(SWC_STBY_CYCLES - SWC_HALT_CYCLES - 1);
          end else begin
            state_next = SWC_HALT;
            cnt_next   = SWC_CNT_W'(SWC_HALT_CYCLES - 1);
          end
        end
      end
      SWC_TIMEOUT: begin
        if (cnt_reg == '0) begin
          state_next = SWC_HALT;
          cnt_next   = SWC_CNT_W'(SWC_HALT_CYCLES - 1);
        end else begin
          cnt_next = cnt_reg - SWC_CNT_W'(1);
        end
      end
      SWC_HALT: begin
        if (cnt_reg == '0) begin
          state_next = SWC_RUN;
        end else begin
          cnt_next = cnt_reg - SWC_CNT_W'(1);
        end
      end
      default: begin
        state_next = SWC_RUN;
      end
    endcase
  end

  // Synchronous reset returns to run, so the core restarts from its vector.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= SWC_RUN;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_reg <= SWC_MODE_IDLE;
    end else if (state_reg == SWC_RUN && enter) begin
      mode_reg <= swc_mode_t'(cfg.sleep_sel);
    end
  end

  // Marks that the wake came from an interrupt that the core must service.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_wake_reg <= 1'b0;
    end else if (state_reg == SWC_SLEEP && wake_any) begin
      irq_wake_reg <= !(mode_reg == SWC_MODE_ADC_NR && wake_src.timer2_event &&
                        !cfg.timer2_async_select && !wake_src.adc_done);
    end
  end

  // Clock gating per mode; only clocks are gated, never storage contents.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clk_ctrl <= '{cpu_clk_en: 1'b1, io_clk_en: 1'b1, osc_en: 1'b1,
                    adc_clk_en: 1'b1, timer2_run: 1'b1, adc_start: 1'b0};
    end else if (state_next == SWC_SLEEP) begin
      clk_ctrl.cpu_clk_en <= 1'b0;
      clk_ctrl.io_clk_en  <= (state_reg == SWC_RUN) ?
                             (cfg.sleep_sel == SWC_MODE_IDLE) : (mode_reg == SWC_MODE_IDLE);
      clk_ctrl.osc_en     <= (state_reg == SWC_RUN) ?
                             !(cfg.sleep_sel == SWC_MODE_PWR_DOWN ||
                               cfg.sleep_sel == SWC_MODE_PWR_SAVE) : !osc_stopped;
      clk_ctrl.adc_clk_en <= (state_reg == SWC_RUN) ? (cfg.sleep_sel[2:1] == 2'h0) :
                             (mode_reg == SWC_MODE_IDLE || mode_reg == SWC_MODE_ADC_NR);
      clk_ctrl.timer2_run <= (state_reg == SWC_RUN) ?
                             (cfg.sleep_sel[1:0] != 2'h2 || cfg.sleep_sel[2] == 1'b0 &&
                              cfg.sleep_sel[1:0] != 2'h2) &&
                             !(cfg.sleep_sel[0] && cfg.sleep_sel[1] && !cfg.timer2_async_select) :
                             clk_ctrl.timer2_run;
      clk_ctrl.adc_start  <= (state_reg == SWC_RUN) && cfg.adc_enabled &&
                             (cfg.sleep_sel[2:1] == 2'h0);
    end else begin
      clk_ctrl <= '{cpu_clk_en: 1'b1, io_clk_en: 1'b1, osc_en: 1'b1,
                    adc_clk_en: 1'b1, timer2_run: 1'b1, adc_start: 1'b0};
      clk_ctrl.cpu_clk_en <= (state_next == SWC_RUN);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sleeping      <= 1'b0;
      active_mode   <= 3'h0;
      irq_a_pending <= 1'b0;
      irq_take      <= 1'b0;
      resume_core   <= 1'b0;
      timer2_irq_ok <= 1'b0;
    end else begin
      sleeping      <= (state_next != SWC_RUN);
      active_mode   <= mode_reg;
      irq_a_pending <= irq_a_req & (instr_done | (state_reg != SWC_RUN) |
                                    (cfg.irq_a_sense != SWC_SENSE_LOW));
      irq_take      <= (state_reg == SWC_HALT) && (cnt_reg == '0) && irq_wake_reg;
      resume_core   <= (state_reg == SWC_HALT) && (cnt_reg == '0);
      timer2_irq_ok <= !((state_reg != SWC_RUN) && mode_reg == SWC_MODE_ADC_NR &&
                         !cfg.timer2_async_select);
    end
  end

endmodule

// *** swc_sva.sv ***
// Port checker for the sleep and wake-up controller.
`timescale 1ns/1ps
module swc_sva
  import swc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = SWC_TIMEOUT_DEF,
  parameter int unsigned WDT_DIV        = SWC_WDT_DIV_DEF
) (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       sleep_instr,
  input wire logic       instr_done,
  input wire logic       ext_irq_pin_a,
  input wire swc_cfg_t   cfg,
  input wire swc_wake_t  wake_src,
  input wire swc_clk_t   clk_ctrl,
  input wire logic       sleeping,
  input wire logic [2:0] active_mode,
  input wire logic       irq_a_pending,
  input wire logic       irq_take,
  input wire logic       resume_core,
  input wire logic       timer2_irq_ok
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic [2:0] sel = cfg.sleep_sel;

  sleep_entry_a: assert property (sleep_instr && cfg.sleep_arm && sel == 3'h0 && !sleeping |=> sleeping)
    else $error("idle entry missed");
  arm_guard_a: assert property (sleep_instr && !cfg.sleep_arm && !sleeping |=> !sleeping)
    else $error("slept without arm");
  mode_guard_a: assert property (sleep_instr && !sleeping && (sel[2:1] == 2'h2
    || (sel[2:1] == 2'h3 && !cfg.ext_crystal)) |=> !sleeping)
    else $error("illegal mode entered");
  cpu_stop_a: assert property ($rose(sleeping) |-> !clk_ctrl.cpu_clk_en)
    else $error("cpu clock kept");
  adc_kick_a: assert property ($rose(sleeping) && $past(sel[2:1]) == 2'h0 && cfg.adc_enabled
    |-> clk_ctrl.adc_start)
    else $error("no adc start");
  mask_block_a: assert property (!(cfg.irq_a_mask && cfg.global_ie) [*4] |-> !irq_a_pending)
    else $error("masked request");
  resume_edge_a: assert property (resume_core |-> $fell(sleeping))
    else $error("resume without wake");
  standby_fast_a: assert property (sleeping && active_mode == 3'h6 && wake_src.twi_match
    |-> ##[1:8] resume_core)
    else $error("standby wake slow");
  low_sync_a: assert property (cfg.irq_a_sense == SWC_SENSE_LOW && $rose(irq_a_pending)
    |-> !$past(ext_irq_pin_a, 3))
    else $error("unsynchronised level");
  t2_irq_a: assert property ($past(sleeping) && sleeping && active_mode == 3'h1
    && !cfg.timer2_async_select |-> !timer2_irq_ok)
    else $error("sync timer irq allowed");

  idle_wake_c: cover property (resume_core && active_mode == 3'h0);
  pd_wake_c: cover property (resume_core && active_mode == 3'h2);
  pend_c: cover property ($rose(irq_a_pending));
endmodule

bind sleep_wakeup_control swc_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .WDT_DIV(WDT_DIV)) u_sva (
  .sys_clk, .reset_n, .sleep_instr, .instr_done, .ext_irq_pin_a, .cfg, .wake_src, .clk_ctrl,
  .sleeping, .active_mode, .irq_a_pending, .irq_take, .resume_core, .timer2_irq_ok);

// *** swc_core_model.sv ***
// Behavioural core and pin driver facing the sleep controller.
`timescale 1ns/1ps
module swc_core_model (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic do_sleep,
  input  wire logic pin_level,
  output logic      sleep_instr,
  output logic      instr_done,
  output logic      ext_irq_pin_a
);
  logic [1:0] step_reg;

  // Instructions complete every third cycle.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      step_reg <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      step_reg <= (step_reg == 2'h2) ? 2'h0 : step_reg + 2'h1;
      instr_done <= (step_reg == 2'h2);
    end
  end

  always_ff @(posedge sys_clk) begin
    sleep_instr <= do_sleep;
    ext_irq_pin_a <= pin_level;
  end
endmodule

// *** tb_sleep_wakeup_control.sv ***
// Self-checking testbench for the sleep and wake-up controller.
`timescale 1ns/1ps
module tb_sleep_wakeup_control;
  import swc_pkg::*;
  logic       sys_clk, reset_n, do_sleep, pin_level, sleep_instr, instr_done, ext_irq_pin_a;
  logic       sleeping, irq_a_pending, irq_take, resume_core, timer2_irq_ok;
  logic [2:0] active_mode;
  swc_cfg_t   cfg;
  swc_wake_t  wake_src;
  swc_clk_t   clk_ctrl;
  int         fails, comparisons;

  sleep_wakeup_control #(.TIMEOUT_CYCLES(16), .WDT_DIV(4)) u_dut (.sys_clk, .reset_n,
    .sleep_instr, .instr_done, .ext_irq_pin_a, .cfg, .wake_src, .clk_ctrl, .sleeping,
    .active_mode, .irq_a_pending, .irq_take, .resume_core, .timer2_irq_ok);
  swc_core_model u_core (.sys_clk, .reset_n, .do_sleep, .pin_level, .sleep_instr,
    .instr_done, .ext_irq_pin_a);

  always #2.5 sys_clk = ~sys_clk;

  task automatic tally_and_finish();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  // Called at a rising edge; returns at a falling edge with entry settled.
  task automatic sleep_now(output logic kick);
    kick = 1'b0;
    do_sleep <= 1'b1;
    @(posedge sys_clk);
    do_sleep <= 1'b0;
    repeat (4) begin
      @(negedge sys_clk);
      kick = kick | clk_ctrl.adc_start;
    end
  endtask

  task automatic wait_resume(input int lim, output int n, output logic took);
    n = 0;
    while (resume_core !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    took = irq_take;
  endtask

  task automatic t_refuse();
    logic kick;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      cfg.sleep_arm <= (i != 0);
      cfg.sleep_sel <= (i == 0) ? 3'h0 : 3'h3 + i[2:0];
      sleep_now(kick);
      check(sleeping === 1'b0 && clk_ctrl === 6'h3e, "bad entry");
    end
  endtask

  task automatic t_wake(input logic [2:0] sel, input int idx, input int lo, input int hi,
                        input logic tk);
    int   n;
    logic took, kick;
    @(posedge sys_clk);
    cfg.sleep_sel <= sel;
    sleep_now(kick);
    check(sleeping === 1'b1 && active_mode === sel, "no sleep");
    check(kick === (sel[2:1] == 2'h0), "adc start");
    check(clk_ctrl.cpu_clk_en === 1'b0, "cpu clock");
    check(clk_ctrl.osc_en === (sel[2:1] != 2'h1), "osc");
    check(clk_ctrl.io_clk_en === (sel == 3'h0), "io clock");
    check(clk_ctrl.adc_clk_en === (sel[2:1] == 2'h0), "adc clock");
    check(clk_ctrl.timer2_run === (sel[1:0] != 2'h2 && (sel[1:0] != 2'h3 || cfg.timer2_async_select)),
          "timer2 run");
    if (sel == 3'h1 && !tk)
      check(timer2_irq_ok === 1'b0, "timer irq");
    @(posedge sys_clk);
    wake_src <= 6'h1 << idx;
    wait_resume(hi, n, took);
    check(n >= lo && resume_core === 1'b1, "wake time");
    check(took === tk, "irq take");
    @(posedge sys_clk);
    wake_src <= 6'h0;
  endtask

  task automatic t_pd_level();
    int   n;
    logic took, kick;
    @(posedge sys_clk);
    cfg.sleep_sel <= 3'h2;
    sleep_now(kick);
    @(posedge sys_clk);
    pin_level <= 1'b0;
    repeat (2) @(posedge sys_clk);
    pin_level <= 1'b1;
    repeat (30) @(negedge sys_clk);
    check(sleeping === 1'b1, "glitch woke");
    @(posedge sys_clk);
    pin_level <= 1'b0;
    wait_resume(120, n, took);
    check(n >= 16 && resume_core === 1'b1, "level wake");
    @(posedge sys_clk);
    pin_level <= 1'b1;
  endtask

  task automatic t_reset_sleep();
    logic kick;
    @(posedge sys_clk);
    cfg.sleep_sel <= 3'h2;
    sleep_now(kick);
    check(sleeping === 1'b1, "no sleep");
    @(posedge sys_clk);
    do_reset();
    @(negedge sys_clk);
    check(sleeping === 1'b0 && clk_ctrl === 6'h3e, "reset wake");
  endtask

  task automatic t_sense();
    logic seen, rest;
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 3; m++) begin
        rest = (s != 3);
        @(posedge sys_clk);
        cfg.irq_a_sense <= s[1:0];
        cfg.irq_a_mask <= (m != 0);
        cfg.global_ie <= (m != 1);
        pin_level <= rest;
        do_reset();
        pin_level <= ~rest;
        repeat (2) @(posedge sys_clk);
        if (s != 0)
          pin_level <= rest;
        seen = 1'b0;
        repeat (12) begin
          @(negedge sys_clk);
          seen = seen | irq_a_pending;
        end
        check(seen === (m == 2), "sense");
      end
    end
  endtask

  initial begin
    #50us;
    fails++;
    tally_and_finish();
  end

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    do_sleep = 1'b0;
    pin_level = 1'b1;
    wake_src = '0;
    cfg = '0;
    cfg.adc_enabled = 1'b1;
    cfg.global_ie = 1'b1;
    cfg.irq_a_mask = 1'b1;
    cfg.timer2_irq_en = 1'b1;
    fails = 0;
    comparisons = 0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check(clk_ctrl === 6'h3e && sleeping === 1'b0 && resume_core === 1'b0, "reset");
    t_refuse();
    t_wake(3'h0, 0, 4, 12, 1'b1);
    t_wake(3'h1, 5, 4, 12, 1'b1);
    t_wake(3'h1, 1, 4, 12, 1'b0);
    t_wake(3'h2, 4, 16, 80, 1'b1);
    @(posedge sys_clk);
    cfg.timer2_async_select <= 1'b1;
    cfg.ext_crystal <= 1'b1;
    t_wake(3'h3, 1, 16, 80, 1'b1);
    t_wake(3'h6, 4, 1, 8, 1'b1);
    t_wake(3'h7, 1, 1, 8, 1'b1);
    t_pd_level();
    t_reset_sleep();
    t_sense();
    tally_and_finish();
  end
endmodule
